// ===== hw/stxc_consts.svh
`ifndef STXC_CONSTS_SVH
`define STXC_CONSTS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define STXC_ADDR_TXCTL    12'h000
`define STXC_ADDR_SRG      12'h004
`define STXC_ADDR_DATA     12'h008
`define STXC_ADDR_STATUS   12'h00C
// ----------------------------------------
// transmit control fields
// ----------------------------------------
`define STXC_TXCTL_WMASK   32'hFFFF_7FF0
`define STXC_TXCTL_RESET   32'h0000_0000
`define STXC_FRLEN1_LSB    8
`define STXC_WDLEN1_LSB    5
`define STXC_REVRS_BIT     4
`define STXC_COMPAND_LSB   19
`define STXC_WDLEN2_LSB    21
// ----------------------------------------
// rate generator fields
// ----------------------------------------
`define STXC_SRG_RESET     32'h2000_0001
`define STXC_SYNC_EN_BIT   31
`define STXC_CLK_POL_BIT   30
`define STXC_CLK_MODE_BIT  29
`define STXC_FS_MODE_BIT   28
`define STXC_PERIOD_LSB    16
`define STXC_WIDTH_LSB     8
`define STXC_DIVIDER_LSB   0
`endif

// ===== hw/stxc_pkg.sv
package stxc_pkg;
   typedef struct packed {
      logic       gen_clock_sync_enable;
      logic       ext_clock_polarity;
      logic       gen_input_clock_mode;
      logic       tx_frame_sync_mode;
      logic [11:0] frame_period;
      logic [7:0] frame_pulse_width;
      logic [7:0] gen_clock_divider;
   } stxc_srg_t;

   typedef struct packed {
      logic       phase2;
      logic [6:0] frlen2;
      logic [2:0] wdlen2;
      logic [1:0] tx_companding_select;
      logic       fig;
      logic [1:0] datdly;
      logic       rsv15;
      logic [6:0] tx_phase1_frame_words;
      logic [2:0] tx_phase1_word_size;
      logic       tx_bit_reverse_enable;
      logic [3:0] rsv;
   } stxc_txctl_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SYNC  = 2'b01,
      ST_SHIFT = 2'b10
   } stxc_state_t;
endpackage

// ===== hw/stxc_fifo.sv
`timescale 1ns/100ps
module stxc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk_i,
   input  wire logic             nrst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic [WIDTH-1:0]      out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0]      wr_reg;
   logic [AW:0]      rd_reg;
   logic             push;
   logic             pop;

   assign in_ready_o  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_reg != rd_reg;
   assign out_data_o  = mem_reg[rd_reg[AW-1:0]];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem_reg[wr_reg[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
      end
   end

   a_fifo_no_overflow: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (wr_reg - rd_reg) <= (AW+1)'(DEPTH)) else $error("fifo overfilled");
endmodule

// ===== hw/stxc_top.sv
`timescale 1ns/100ps
`include "stxc_consts.svh"
module stxc_top (
   input  wire logic        mclk_i,
   input  wire logic        nrst_i,
   input  wire logic        hsel_i,
   input  wire logic [11:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        ext_clk_i,
   input  wire logic        rx_frame_sync_i,
   output logic             serial_clk_o,
   output logic             frame_sync_o,
   output logic             serial_data_o
);
   import stxc_pkg::*;

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   stxc_txctl_t txctl_reg;
   stxc_srg_t   srg_reg;
   logic        wr_pend_reg;
   logic [11:0] addr_reg;
   logic [31:0] hrdata_reg;
   logic        fifo_in_ready;
   logic [31:0] fifo_data;
   logic        fifo_valid;
   logic        fifo_pop;
   logic        wr_stall;
   logic        phase_act;

   wire addr_phase = hsel_i && hready_i && htrans_i[1];

   // a data write that finds the fifo full holds the bus until space appears
   assign wr_stall = wr_pend_reg && (addr_reg == `STXC_ADDR_DATA) && !fifo_in_ready;
   assign hreadyout_o = !wr_stall;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = hrdata_reg;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_pend_reg <= 1'b0;
         addr_reg    <= '0;
      end else if (!wr_stall) begin
         wr_pend_reg <= addr_phase && hwrite_i;
         addr_reg    <= haddr_i;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         txctl_reg <= stxc_txctl_t'(`STXC_TXCTL_RESET);
         srg_reg   <= stxc_srg_t'(`STXC_SRG_RESET);
      end else if (wr_pend_reg && !wr_stall) begin
         if (addr_reg == `STXC_ADDR_TXCTL) begin
            txctl_reg <= stxc_txctl_t'(hwdata_i & `STXC_TXCTL_WMASK);
         end
         if (addr_reg == `STXC_ADDR_SRG) begin
            srg_reg <= stxc_srg_t'(hwdata_i);
         end
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hrdata_reg <= '0;
      end else if (addr_phase && !hwrite_i) begin
         unique case (haddr_i)
            `STXC_ADDR_TXCTL:  hrdata_reg <= 32'(txctl_reg);
            `STXC_ADDR_SRG:    hrdata_reg <= 32'(srg_reg);
            `STXC_ADDR_STATUS: hrdata_reg <= {29'h0, phase_act, fifo_valid, fifo_in_ready};
            default:           hrdata_reg <= '0;
         endcase
      end
   end

   stxc_fifo #(
      .WIDTH (32),
      .DEPTH (16)
   ) u_fifo (
      .mclk_i      (mclk_i),
      .nrst_i      (nrst_i),
      .in_data_i   (hwdata_i),
      .in_valid_i  (wr_pend_reg && addr_reg == `STXC_ADDR_DATA),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop)
   );

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [1:0] clks_sync_reg;
   logic [1:0] rfs_sync_reg;
   logic       clks_last_reg;
   logic       rfs_last_reg;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         clks_sync_reg <= '0;
         rfs_sync_reg  <= '0;
         clks_last_reg <= 1'b0;
         rfs_last_reg  <= 1'b0;
      end else begin
         clks_sync_reg <= {clks_sync_reg[0], ext_clk_i};
         rfs_sync_reg  <= {rfs_sync_reg[0], rx_frame_sync_i};
         clks_last_reg <= clks_sync_reg[1];
         rfs_last_reg  <= rfs_sync_reg[1];
      end
   end

   wire clks_rise = clks_sync_reg[1] && !clks_last_reg;
   wire clks_fall = !clks_sync_reg[1] && clks_last_reg;
   wire rfs_rise  = rfs_sync_reg[1] && !rfs_last_reg;
   wire clks_edge = srg_reg.ext_clock_polarity ? clks_fall : clks_rise;
   // internal mode counts every mclk, external only on the chosen pin edge
   wire gen_tick  = srg_reg.gen_input_clock_mode ? 1'b1 : clks_edge;
   wire ext_sync  = srg_reg.gen_clock_sync_enable && !srg_reg.gen_input_clock_mode;

   // ----------------------------------------
   // clock divider
   // ----------------------------------------
   logic [7:0] div_cnt_reg;
   logic       gen_clk_reg;
   logic       bit_en;

   // period is divider+1 input clocks, high for the first part; a divider of 0 holds it high
   wire [7:0] clk_high = {1'b0, srg_reg.gen_clock_divider[7:1]} + 8'h01;
   wire       div_wrap = div_cnt_reg >= srg_reg.gen_clock_divider;
   wire [7:0] div_next = div_wrap ? 8'h00 : div_cnt_reg + 8'h01;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         // starts at the reset divider so the first tick is a rising edge
         div_cnt_reg <= 8'(`STXC_SRG_RESET);
         gen_clk_reg <= 1'b0;
      end else if (ext_sync && rfs_rise) begin
         div_cnt_reg <= srg_reg.gen_clock_divider;
         gen_clk_reg <= 1'b0;
      end else if (gen_tick) begin
         div_cnt_reg <= div_next;
         gen_clk_reg <= div_next < clk_high;
      end
   end

   // one-cycle enable at each rising edge of the generated clock
   assign bit_en = gen_tick && div_wrap && !(ext_sync && rfs_rise);
   assign serial_clk_o = gen_clk_reg;

   // ----------------------------------------
   // frame sync generation
   // ----------------------------------------
   logic [11:0] per_cnt_reg;
   logic        sync_armed_reg;
   logic        gen_fs_reg;

   function automatic logic [5:0] word_bits(input logic [2:0] code);
      unique case (code)
         3'h0:    word_bits = 6'd8;
         3'h1:    word_bits = 6'd12;
         3'h2:    word_bits = 6'd16;
         3'h3:    word_bits = 6'd20;
         3'h4:    word_bits = 6'd24;
         default: word_bits = 6'd32;
      endcase
   endfunction

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync_armed_reg <= 1'b0;
      end else if (!ext_sync) begin
         sync_armed_reg <= 1'b0;
      end else if (rfs_rise) begin
         sync_armed_reg <= 1'b1;
      end else if (bit_en && per_cnt_reg == 12'h000) begin
         sync_armed_reg <= 1'b0;
      end
   end

   // no restart while shifting: a second start would pop a word that is never sent
   wire frame_start = bit_en && fifo_valid && !phase_act &&
                      (ext_sync ? sync_armed_reg : per_cnt_reg == 12'h000);

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         per_cnt_reg <= '0;
         gen_fs_reg  <= 1'b0;
      end else if (bit_en) begin
         if (per_cnt_reg >= srg_reg.frame_period || frame_start) begin
            per_cnt_reg <= frame_start ? 12'h001 : 12'h000;
         end else if (per_cnt_reg != 12'h000) begin
            per_cnt_reg <= per_cnt_reg + 12'h001;
         end
         gen_fs_reg <= frame_start ||
                       (gen_fs_reg && per_cnt_reg <= {4'h0, srg_reg.frame_pulse_width});
      end
   end
   assign frame_sync_o = gen_fs_reg;

   // ----------------------------------------
   // phase-1 shifter
   // ----------------------------------------
   stxc_state_t state_reg;
   logic [31:0] shift_reg;
   logic [5:0]  bit_cnt_reg;
   logic [6:0]  word_cnt_reg;
   logic        sdo_reg;

   wire [5:0] wbits = word_bits(txctl_reg.tx_phase1_word_size);
   assign phase_act = state_reg == ST_SHIFT;
   assign fifo_pop  = frame_start ||
                      (phase_act && bit_en && bit_cnt_reg == 6'd1 && word_cnt_reg != 7'h00 && fifo_valid);

   function automatic logic [31:0] load_word(input logic [31:0] d, input logic [5:0] n, input logic rev);
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < 32; i++) begin
         r[i] = d[31-i];
      end
      load_word = rev ? r : (d << (6'd32 - n));
   endfunction

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg    <= ST_IDLE;
         shift_reg    <= '0;
         bit_cnt_reg  <= '0;
         word_cnt_reg <= '0;
         sdo_reg      <= 1'b0;
      end else if (bit_en) begin
         unique case (state_reg)
            ST_IDLE: begin
               sdo_reg <= 1'b0;
               if (frame_start) begin
                  shift_reg    <= load_word(fifo_data, wbits, txctl_reg.tx_bit_reverse_enable);
                  bit_cnt_reg  <= wbits;
                  word_cnt_reg <= txctl_reg.tx_phase1_frame_words;
                  state_reg    <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               sdo_reg     <= shift_reg[31];
               shift_reg   <= shift_reg << 1;
               bit_cnt_reg <= bit_cnt_reg - 6'd1;
               if (bit_cnt_reg == 6'd1) begin
                  if (word_cnt_reg == 7'h00 || !fifo_valid) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     shift_reg    <= load_word(fifo_data, wbits, txctl_reg.tx_bit_reverse_enable);
                     bit_cnt_reg  <= wbits;
                     word_cnt_reg <= word_cnt_reg - 7'h01;
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
   assign serial_data_o = sdo_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_written;
      wr_pend_reg && !wr_stall && addr_reg == `STXC_ADDR_TXCTL;
   endsequence

   a_rsv_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      txctl_reg.rsv == 4'h0 && !txctl_reg.rsv15) else $error("reserved bits set");
   a_txctl_store: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      s_written |=> txctl_reg.tx_phase1_frame_words == $past(hwdata_i[14:8])) else $error("frame length lost");
   a_half_rate: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (srg_reg.gen_input_clock_mode && srg_reg.gen_clock_divider == 8'h01 && $stable(srg_reg))
      |=> gen_clk_reg != $past(gen_clk_reg)) else $error("clock not half rate");
   a_sync_wait: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (ext_sync && !sync_armed_reg && !rfs_rise) |-> !frame_start) else $error("frame before sync");
   a_word_start: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (frame_start) |=> bit_cnt_reg == $past(wbits)) else $error("bad word size");
   a_frame_words: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      frame_start |=> word_cnt_reg == $past(txctl_reg.tx_phase1_frame_words)) else $error("bad word count");
   a_rev_load: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (frame_start && txctl_reg.tx_bit_reverse_enable) |=> shift_reg[31] == $past(fifo_data[0]))
      else $error("reversal not applied");
   a_srg_store: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (wr_pend_reg && !wr_stall && addr_reg == `STXC_ADDR_SRG)
      |=> srg_reg.gen_clock_sync_enable == $past(hwdata_i[31]) && srg_reg.frame_period == $past(hwdata_i[27:16]))
      else $error("rate register layout");
endmodule

// ===== verification/stxc_peer.sv
`timescale 1ns/100ps
// ----------------------------------------
// framed serial peer
// ----------------------------------------
module stxc_peer (
   input  wire logic        mclk_i,
   input  wire logic        nrst_i,
   input  wire logic        serial_clk_i,
   input  wire logic        frame_sync_i,
   input  wire logic        serial_data_i,
   input  wire logic [15:0] frame_bits_i
);
   logic rx_bits[$];
   int   frames;
   int   gap;
   int   cnt;
   int   left;
   logic clk_d;

   // data moves on the rising serial edge, so the falling edge is mid-bit
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         clk_d = 1'b0;
         cnt = 0;
         left = 0;
         frames = 0;
         gap = 0;
      end else begin
         cnt++;
         if (clk_d && !serial_clk_i) begin
            gap = cnt;
            cnt = 0;
            // the first data bit follows the sync period by one bit
            if (left > 0) begin
               rx_bits.push_back(serial_data_i);
               left--;
            end else if (frame_sync_i) begin
               frames++;
               left = frame_bits_i;
            end
         end
         clk_d = serial_clk_i;
      end
   end
endmodule

// ===== verification/stxc_top_tb.sv
`timescale 1ns/100ps
`include "stxc_consts.svh"
module stxc_top_tb;
   logic        mclk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        hsel_i = 1'b0;
   logic [11:0] haddr_i = 12'h000;
   logic [1:0]  htrans_i = 2'b00;
   logic        hwrite_i = 1'b0;
   logic [2:0]  hsize_i = 3'b010;
   logic [31:0] hwdata_i = 32'h0000_0000;
   logic        ext_clk_i = 1'b0;
   logic        rx_frame_sync_i = 1'b0;
   logic [31:0] hrdata_o;
   logic        hreadyout_o;
   logic        hresp_o;
   logic        serial_clk_o;
   logic        frame_sync_o;
   logic        serial_data_o;
   logic [15:0] frame_bits = 16'h0000;
   logic [31:0] rd;
   int          mismatches = 0;
   int          n_compared = 0;
   int          f0;
   int          wbits[6] = '{8, 12, 16, 20, 24, 32};

   always #20 mclk_i = ~mclk_i;
   always #60 ext_clk_i = ~ext_clk_i;

   stxc_top uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
      .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .ext_clk_i(ext_clk_i), .rx_frame_sync_i(rx_frame_sync_i),
      .serial_clk_o(serial_clk_o), .frame_sync_o(frame_sync_o), .serial_data_o(serial_data_o));

   stxc_peer peer (.mclk_i(mclk_i), .nrst_i(nrst_i), .serial_clk_i(serial_clk_o), .frame_sync_i(frame_sync_o),
      .serial_data_i(serial_data_o), .frame_bits_i(frame_bits));

   // ----------------------------------------
   // reporting
   // ----------------------------------------
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // ----------------------------------------
   // bus master
   // ----------------------------------------
   // sampled at the falling edge: the value then stands at the next rising edge
   task automatic wait_ready();
      int n;
      n = 0;
      @(negedge mclk_i);
      while (hreadyout_o !== 1'b1 && n < 400) begin
         @(negedge mclk_i);
         n++;
      end
      if (n >= 400) begin
         mismatches++;
         summarize();
      end
      rd = hrdata_o;
      @(posedge mclk_i);
   endtask

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel_i <= 1'b1;
      htrans_i <= 2'b10;
      haddr_i <= a;
      hwrite_i <= w;
      hsize_i <= 3'b010;
      wait_ready();
      hsel_i <= 1'b0;
      htrans_i <= 2'b00;
      hwdata_i <= d;
      wait_ready();
   endtask

   task automatic pulse_sync();
      rx_frame_sync_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      rx_frame_sync_i <= 1'b0;
   endtask

   // ----------------------------------------
   // one frame of nw words, nb bits each
   // ----------------------------------------
   task automatic run_frame(input logic [31:0] ctl, input int nw, input int nb, input logic rev);
      logic [31:0] v;
      logic [31:0] d;
      int          n;
      int          fs;
      peer.rx_bits.delete();
      fs = peer.frames;
      frame_bits <= 16'(nw * nb);
      xfer(1'b1, `STXC_ADDR_TXCTL, ctl);
      for (int i = 0; i < nw; i++) begin
         xfer(1'b1, `STXC_ADDR_DATA, 32'hC3A5_96E1 + 32'(i) * 32'h1111_1111);
      end
      n = 0;
      while (peer.rx_bits.size() < nw * nb && n < 4000) begin
         @(posedge mclk_i);
         n++;
      end
      if (n >= 4000) begin
         mismatches++;
         summarize();
      end
      repeat (80) @(posedge mclk_i);
      check(32'(peer.frames - fs), 32'h0000_0001);
      for (int i = 0; i < nw; i++) begin
         v = 32'h0000_0000;
         for (int b = 0; b < nb; b++) begin
            if (rev) begin
               v[b] = peer.rx_bits[i * nb + b];
            end else begin
               v = {v[30:0], peer.rx_bits[i * nb + b]};
            end
         end
         d = (32'hC3A5_96E1 + 32'(i) * 32'h1111_1111) & ~(32'hFFFF_FFFF << nb);
         check(v, d);
      end
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge mclk_i);
      nrst_i <= 1'b1;
      @(posedge mclk_i);
      xfer(1'b0, `STXC_ADDR_SRG, 32'h0000_0000);
      check(rd, 32'h2000_0001);
      xfer(1'b0, `STXC_ADDR_TXCTL, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      xfer(1'b1, `STXC_ADDR_TXCTL, 32'hFFFF_FFFF);
      xfer(1'b0, `STXC_ADDR_TXCTL, 32'h0000_0000);
      check(rd, 32'hFFFF_7FF0);
      xfer(1'b1, `STXC_ADDR_SRG, 32'h9ABC_5A3C);
      xfer(1'b0, `STXC_ADDR_SRG, 32'h0000_0000);
      check(rd, 32'h9ABC_5A3C);
      xfer(1'b1, `STXC_ADDR_SRG, 32'h2000_0001);
      xfer(1'b1, 12'h010, 32'hFFFF_FFFF);
      xfer(1'b0, 12'h010, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      check({31'h0, hresp_o}, 32'h0000_0000);
      for (int k = 0; k < 6; k++) begin
         run_frame({17'h0, 7'(k % 3), 3'(k), 5'h00}, k % 3 + 1, wbits[k], 1'b0);
         if (k == 0) begin
            check(32'(peer.gap), 32'h0000_0002);
         end
      end
      // both word sizes 32 and companding 1 before reversal
      run_frame(32'h00A8_01B0, 2, 32, 1'b1);
      // sync mode on the external clock holds frames back, so the fifo fills
      xfer(1'b1, `STXC_ADDR_SRG, 32'h8000_0001);
      frame_bits <= 16'h0000;
      f0 = peer.frames;
      for (int i = 0; i < 16; i++) begin
         xfer(1'b1, `STXC_ADDR_TXCTL + 12'(i == 0 ? 0 : 8), i == 0 ? 32'h0000_0F00 : 32'(i));
      end
      xfer(1'b1, `STXC_ADDR_DATA, 32'h0000_0010);
      fork
         xfer(1'b1, `STXC_ADDR_DATA, 32'h0000_0011);
         begin
            repeat (12) @(posedge mclk_i);
            @(negedge mclk_i);
            check({31'h0, hreadyout_o}, 32'h0000_0000);
            check(32'(peer.frames - f0), 32'h0000_0000);
            @(posedge mclk_i);
            pulse_sync();
         end
      join
      for (int k = 0; k < 10; k++) begin
         xfer(1'b0, `STXC_ADDR_STATUS, 32'h0000_0000);
         if (rd[1] === 1'b1) begin
            pulse_sync();
            repeat (300) @(posedge mclk_i);
         end
      end
      check(32'(peer.frames - f0) >= 32'h0000_0001, 32'h0000_0001);
      xfer(1'b0, `STXC_ADDR_STATUS, 32'h0000_0000);
      check(rd, 32'h0000_0001);
      summarize();
   end
endmodule
